// *** lcd_ctrl_pkg.sv ***
// Constants and types shared by the LCD control register block
package lcd_ctrl_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] display_control_idx = 8'hc1;
	localparam logic [7:0] display_control_two_idx = 8'hc2;
	localparam logic [11:0] display_control_addr = {2'h0, display_control_idx, 2'h0};
	localparam logic [11:0] display_control_two_addr = {2'h0, display_control_two_idx, 2'h0};
	localparam int addr_w = 12;

	// ****************************************************************
	// Reset values and bits that read as one
	// ****************************************************************
	localparam logic [7:0] display_control_rst = 8'h80;
	localparam logic [7:0] display_control_two_rst = 8'h60;
	localparam logic [7:0] display_control_wmask = 8'h7f;
	localparam logic [7:0] display_control_two_wmask = 8'h9f;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int drive_power_switch_pos = 6;
	localparam int controller_run_pos = 5;
	localparam int display_data_show_pos = 4;
	localparam int frame_clock_source_select_pos = 3;
	localparam int waveform_type_select_pos = 7;

	// ****************************************************************
	// Duty field codes
	// ****************************************************************
	localparam logic [3:0] duty_full = 4'h0;
	localparam logic [3:0] duty_zero = 4'h7;

	// Counter widths
	localparam int sub_div_w = 2;
	localparam int sys_div_w = 8;
	localparam int duty_phase_w = 5;

	// Bus request bundle
	typedef struct packed {
		logic [addr_w-1:0] addr;
		logic write;
		logic [31:0] wdata;
	} apb_req_t;

	// Decoded control fields
	typedef struct packed {
		logic power;
		logic run;
		logic show;
		logic src_sys;
		logic [2:0] div_sel;
		logic wave_b;
		logic [3:0] duty;
	} lcd_fields_t;
endpackage

// *** lcd_control_registers.sv ***
// LCD controller control registers, frame clock select and drive controls
`timescale 1ns/1ns
// Function
// [RQ1] Drive supply output on while power switch bit is 1, off while 0.
// [RQ2] Charge pulse duty: 0000 full, 1..6 eighths, 0111 zero, 10xx 1/16, 11xx 1/32.
// [RQ3] Source bit 0: frame tick from sub-clock, undivided, /2 or /4.
// [RQ4] Source bit 1: frame tick from system clock divided by 2 up to 256.
// [RQ5] Controller runs only while run bit is 1; show bit picks blank or data.
// [RQ6] Waveform select 0 drives A waveform, 1 drives B waveform.
module lcd_control_registers
	import lcd_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_w-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sub_clock,
	output logic drive_power_on,
	output logic controller_active,
	output logic display_data_shown,
	output logic frame_tick,
	output logic charge_pulse,
	output logic waveform_b
);
	// ****************************************************************
	// Register storage and decode
	// ****************************************************************
	logic [7:0] display_control_r;
	logic [7:0] display_control_two_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	apb_req_t req;
	lcd_fields_t f;
	logic setup;
	logic hit_one;
	logic hit_two;

	// Bundle the bus request and decode it
	always_comb begin
		req.addr = paddr;
		req.write = pwrite;
		req.wdata = pwdata;
		setup = psel & ~penable;
		hit_one = (req.addr == display_control_addr);
		hit_two = (req.addr == display_control_two_addr);
	end

	// Field view of the two registers
	always_comb begin
		f.power = display_control_r[drive_power_switch_pos];
		f.run = display_control_r[controller_run_pos];
		f.show = display_control_r[display_data_show_pos];
		f.src_sys = display_control_r[frame_clock_source_select_pos];
		f.div_sel = display_control_r[2:0];
		f.wave_b = display_control_two_r[waveform_type_select_pos];
		f.duty = display_control_two_r[3:0];
	end

	// ****************************************************************
	// APB slave: answer registered, one access cycle
	// ****************************************************************
	// Ready and error prepared in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup & ~(hit_one | hit_two);
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prdata_r <= 32'h0;
		end else if (setup & ~req.write) begin
			if (hit_one) begin
				prdata_r <= {24'h0, display_control_r};
			end else if (hit_two) begin
				prdata_r <= {24'h0, display_control_two_r};
			end else begin
				prdata_r <= 32'h0;
			end
		end
	end

	// Writes land at the access edge; fixed-one bits keep their value
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			display_control_r <= display_control_rst;
			display_control_two_r <= display_control_two_rst;
		end else if (psel & penable & pready_r & req.write) begin
			if (hit_one) begin
				display_control_r <= (req.wdata[7:0] & display_control_wmask)
					| (display_control_rst & ~display_control_wmask);
			end
			if (hit_two) begin
				display_control_two_r <= (req.wdata[7:0] & display_control_two_wmask)
					| (display_control_two_rst & ~display_control_two_wmask);
			end
		end
	end

	// ****************************************************************
	// Sub-clock synchroniser and edge detect
	// ****************************************************************
	logic sub_meta_r;
	logic sub_sync_r;
	logic sub_last_r;
	logic sub_edge;

	// Two flops before any logic looks at the pin
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sub_meta_r <= 1'b0;
			sub_sync_r <= 1'b0;
			sub_last_r <= 1'b0;
		end else begin
			sub_meta_r <= sub_clock;
			sub_sync_r <= sub_meta_r;
			sub_last_r <= sub_sync_r;
		end
	end

	assign sub_edge = sub_sync_r & ~sub_last_r;

	// ****************************************************************
	// Frame clock dividers
	// ****************************************************************
	logic [sub_div_w-1:0] sub_cnt_r;
	logic [sys_div_w-1:0] sys_cnt_r;
	logic [sys_div_w-1:0] sys_mask;
	logic sub_tick;
	logic sys_tick;
	logic frame_tick_r;

	// Dividers count only while the controller runs
	always_ff @(posedge clk_sys) begin
		if (srst | ~f.run) begin
			sub_cnt_r <= '0;
			sys_cnt_r <= '0;
		end else begin
			if (sub_edge) begin
				sub_cnt_r <= sub_cnt_r + 1'b1;
			end
			sys_cnt_r <= sys_cnt_r + 1'b1;
		end
	end

	// Sub-clock tick: every edge, every second, every fourth
	always_comb begin
		if (f.div_sel[1]) begin
			sub_tick = sub_edge & (&sub_cnt_r); // [RQ3]
		end else if (f.div_sel[0]) begin
			sub_tick = sub_edge & sub_cnt_r[0]; // [RQ3]
		end else begin
			sub_tick = sub_edge; // [RQ3]
		end
	end

	// System tick every 2 to the (select + 1) cycles
	always_comb begin
		sys_mask = 8'hff >> (3'h7 - f.div_sel); // [RQ4]
		sys_tick = ((sys_cnt_r & sys_mask) == sys_mask); // [RQ4]
	end

	// Frame tick from the chosen source, halted when not running
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			frame_tick_r <= 1'b0;
		end else begin
			frame_tick_r <= f.run & (f.src_sys ? sys_tick : sub_tick); // [RQ3] [RQ4] [RQ5]
		end
	end

	// ****************************************************************
	// Charge/discharge pulse duty
	// ****************************************************************
	logic [duty_phase_w-1:0] phase_r;
	logic charge_nxt;
	logic charge_r;

	// Phase advances once per frame tick
	always_ff @(posedge clk_sys) begin
		if (srst | ~f.run) begin
			phase_r <= '0;
		end else if (frame_tick_r) begin
			phase_r <= phase_r + 1'b1;
		end
	end

	// Duty decode against the phase
	always_comb begin
		if (f.duty[3]) begin
			if (f.duty[2]) begin
				charge_nxt = (phase_r == 5'h00); // [RQ2]
			end else begin
				charge_nxt = (phase_r[3:0] == 4'h0); // [RQ2]
			end
		end else if (f.duty == duty_full) begin
			charge_nxt = 1'b1; // [RQ2]
		end else if (f.duty == duty_zero) begin
			charge_nxt = 1'b0; // [RQ2]
		end else begin
			charge_nxt = ({1'b0, phase_r[2:0]} < f.duty); // [RQ2]
		end
	end

	// ****************************************************************
	// Drive outputs
	// ****************************************************************
	logic power_r;
	logic active_r;
	logic shown_r;
	logic wave_r;

	// Registered controls toward the panel driver
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			power_r <= 1'b0;
			active_r <= 1'b0;
			shown_r <= 1'b0;
			wave_r <= 1'b0;
			charge_r <= 1'b0;
		end else begin
			power_r <= f.power; // [RQ1]
			active_r <= f.run; // [RQ5]
			shown_r <= f.show; // [RQ5]
			wave_r <= f.wave_b; // [RQ6]
			charge_r <= f.run & charge_nxt; // [RQ2] [RQ5]
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign drive_power_on = power_r;
	assign controller_active = active_r;
	assign display_data_shown = shown_r;
	assign frame_tick = frame_tick_r;
	assign charge_pulse = charge_r;
	assign waveform_b = wave_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_power_write;
		psel & penable & pready & pwrite & hit_one;
	endsequence

	a_power_follows_write: assert property (@(posedge clk_sys) disable iff (srst) // [RQ1]
		s_power_write ##1 1'b1 |=> (drive_power_on == $past(pwdata[drive_power_switch_pos], 2)))
		else $error("drive power does not follow written switch bit");

	a_duty_zero_code: assert property (@(posedge clk_sys) disable iff (srst) // [RQ2]
		(f.duty == duty_zero) [*2] |=> !charge_pulse)
		else $error("charge pulse active with zero duty code");

	a_duty_full_code: assert property (@(posedge clk_sys) disable iff (srst) // [RQ2]
		(f.duty == duty_full && f.run) [*2] |=> charge_pulse)
		else $error("charge pulse low with full duty code");

	a_sub_div_one: assert property (@(posedge clk_sys) disable iff (srst) // [RQ3]
		(f.run && !f.src_sys && f.div_sel[1:0] == 2'h0 && sub_edge) |=> frame_tick)
		else $error("undivided sub-clock edge gave no frame tick");

	a_sys_div_two: assert property (@(posedge clk_sys) disable iff (srst) // [RQ4]
		(f.run && f.src_sys && f.div_sel == 3'h0) [*3] |-> (frame_tick != $past(frame_tick)))
		else $error("system clock divide by two does not alternate");

	a_halt_no_tick: assert property (@(posedge clk_sys) disable iff (srst) // [RQ5]
		!f.run [*2] |-> !frame_tick && !charge_pulse)
		else $error("frame logic active while controller halted");

	a_wave_select: assert property (@(posedge clk_sys) disable iff (srst) // [RQ6]
		$changed(f.wave_b) |=> (waveform_b == $past(f.wave_b)))
		else $error("waveform output does not follow select bit");

	a_bus_answer: assert property (@(posedge clk_sys) disable iff (srst)
		setup |=> pready ##1 !pready)
		else $error("bus answer not exactly one cycle after setup");

	a_power_off_hold: assert property (@(posedge clk_sys) disable iff (srst) // [RQ1]
		!f.power [*2] |-> !drive_power_on)
		else $error("drive power on while switch bit is 0");

	a_run_level: assert property (@(posedge clk_sys) disable iff (srst) // [RQ5]
		f.run [*2] |-> controller_active)
		else $error("controller not active while run bit is 1");

	a_unmapped_error: assert property (@(posedge clk_sys) disable iff (srst)
		(psel && penable && pready && !(hit_one || hit_two)) |-> pslverr)
		else $error("unmapped access answered without error");

	a_error_with_ready: assert property (@(posedge clk_sys) disable iff (srst)
		pslverr |-> pready)
		else $error("slave error raised outside the access cycle");
endmodule // lcd_control_registers

// *** lcd_panel_model.sv ***
// Watch crystal and frame counter on the panel side of the LCD control block
`timescale 1ns/1ns
module lcd_panel_model #(
	parameter int half_cycles = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic frame_tick,
	output logic sub_clock,
	output logic [15:0] frame_cnt
);
	int div_cnt = 0;
	// ****************************************************************
	// Crystal runs free, toggling every half_cycles system clocks
	// ****************************************************************
	initial sub_clock = 1'b0;
	always @(posedge clk_sys) begin
		div_cnt <= (div_cnt == half_cycles - 1) ? 0 : div_cnt + 1;
		if (div_cnt == half_cycles - 1) sub_clock <= ~sub_clock;
	end
	// Frames the panel has been driven with
	always @(posedge clk_sys) begin
		if (srst) frame_cnt <= 16'h0000;
		else if (frame_tick) frame_cnt <= frame_cnt + 16'h0001;
	end
endmodule // lcd_panel_model

// *** lcd_control_registers_tb_top.sv ***
// Self-checking bench for the LCD control register block
`timescale 1ns/1ns
module lcd_control_registers_tb_top
	import lcd_ctrl_pkg::*;
;
	logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [addr_w-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, sub_clock, pwr, run, shw, tick, chg, wvb;
	logic [15:0] frames;
	int error_cnt = 0, checks = 0, n, hi;
	lcd_control_registers u_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sub_clock(sub_clock),
		.drive_power_on(pwr), .controller_active(run), .display_data_shown(shw),
		.frame_tick(tick), .charge_pulse(chg), .waveform_b(wvb));
	lcd_panel_model u_panel (.clk_sys(clk_sys), .srst(srst), .frame_tick(tick),
		.sub_clock(sub_clock), .frame_cnt(frames));
	// ****************************************************************
	// Clock, checks and APB master
	// ****************************************************************
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic bail(input string what);
		error_cnt++;
		$display("FAIL t=%0t wait for %s ran out", $time, what);
		tally_and_finish();
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
			input logic [31:0] exp, input logic eerr);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) bail("pready");
		chk({31'h0, pslverr}, {31'h0, eerr}, "slave error");
		if (!w) chk(prdata, exp, "read data");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count edges up to the next frame tick
	task automatic gap(output int c);
		c = 0;
		do begin
			@(posedge clk_sys);
			c++;
		end while (tick !== 1'b1 && c < 5000);
		if (tick !== 1'b1) bail("frame tick");
	endtask
	task automatic period(input int exp);
		gap(n);
		gap(n);
		gap(n);
		chk(n, exp, "frame period");
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		chk({26'h0, pwr, run, shw, tick, chg, wvb}, 32'h0, "outputs after reset");
		apb(display_control_addr, 1'b0, 0, 32'h80, 1'b0);
		apb(display_control_two_addr, 1'b0, 0, 32'h60, 1'b0);
		apb(display_control_addr, 1'b1, 32'h0, 0, 1'b0);
		apb(display_control_addr, 1'b0, 0, 32'h80, 1'b0);
		apb(display_control_two_addr, 1'b1, 32'hffffff1f, 0, 1'b0);
		apb(display_control_two_addr, 1'b0, 0, 32'h7f, 1'b0);
		apb(12'h300, 1'b1, 32'hff, 0, 1'b1);
		apb(12'h300, 1'b0, 0, 32'h0, 1'b1);
		$display("test registers done");
		for (int s = 0; s < 8; s++) begin
			apb(display_control_addr, 1'b1, 32'h78 | s, 0, 1'b0);
			period(2 << s);
		end
		for (int s = 0; s < 4; s++) begin
			apb(display_control_addr, 1'b1, 32'h70 | s, 0, 1'b0);
			period(s == 0 ? 16 : (s == 1 ? 32 : 64));
		end
		$display("test frame clock done");
		apb(display_control_addr, 1'b1, 32'h78, 0, 1'b0);
		for (int c = 0; c < 16; c++) begin
			apb(display_control_two_addr, 1'b1, c, 0, 1'b0);
			repeat (8) @(posedge clk_sys);
			hi = 0;
			repeat (64) begin
				@(posedge clk_sys);
				hi += (chg === 1'b1);
			end
			chk(hi, c == 0 ? 64 : c < 7 ? 8 * c : c == 7 ? 0 : c < 12 ? 4 : 2, "duty");
		end
		$display("test duty done");
		chk({29'h0, pwr, run, shw}, 32'h7, "drive levels");
		apb(display_control_addr, 1'b1, 32'h48, 0, 1'b0);
		repeat (4) @(posedge clk_sys);
		n = {16'h0, frames};
		repeat (64) @(posedge clk_sys);
		chk(frames - n, 0, "frames while halted");
		chk({28'h0, pwr, run, shw, chg}, 32'h8, "halted levels");
		apb(display_control_addr, 1'b1, 32'h10, 0, 1'b0);
		apb(display_control_two_addr, 1'b1, 32'h80, 0, 1'b0);
		repeat (3) @(posedge clk_sys);
		chk({28'h0, pwr, run, shw, wvb}, 32'h3, "power off, show, wave b");
		apb(display_control_two_addr, 1'b1, 32'h00, 0, 1'b0);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, wvb}, 32'h0, "wave a");
		$display("test levels done");
		tally_and_finish();
	end
endmodule // lcd_control_registers_tb_top
